// ---- logic/uart_interrupt_arbiter.sv ----
// interrupt arbitration, context capture and global windows of a four channel uart
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - event sources with programmed high bits set outrank those with zeros
// - receiver bid carries fill count high, rising as its fifo fills
// - transmitter bid rises with the number of empty transmit slots
// - acknowledge falling captures the current winning valid bid
// - acknowledge cycle drives vector, optionally modified with type and channel
// - captured context holds until next acknowledge or update command
// - global fifo windows route to the channel of the captured context
// - capture with no bid above threshold loads all zeros
// - update command write captures like acknowledge; read returns it
// - masked sources never request nor appear in the captured context
// - event sources bid only after their event and above threshold
// - per channel receive start level: not empty, half, three quarters, full
// - per channel transmit start level: not full, half, three quarters, empty
// - seven bit threshold compared with bid bits nine down to three
// - request only when bid strictly greater than threshold
// - channel bits break ties between channels, channel D highest
// - new winner every twenty-two clocks, late changes wait one period
// - bid bits six to three encode the source type; rx bids carry a count bit at six, tx bids count bits at six and five
// - channel field holds channels A to D as zero to three
// - request withdrawn when threshold reaches or exceeds every active bid
module uart_interrupt_arbiter #(
  parameter int TYPE_LSB = 3,
  parameter int CHAN_LSB = 0
) (
  input  wire logic                                          core_clk_i,          // clock
  input  wire logic                                          nrst_i,              // reset
  input  wire logic [uart_irq_pkg::ADDR_W-1:0]               addr_i,              // reg addr
  input  wire logic [uart_irq_pkg::DATA_W-1:0]               wdata_i,             // wr data
  input  wire logic                                          wr_i,                // wr strobe
  input  wire logic                                          rd_i,                // rd strobe
  output logic      [uart_irq_pkg::DATA_W-1:0]               rdata_o,             // rd data
  input  wire logic                                          interrupt_ack_n_i,   // ack, low
  output logic                                               interrupt_request_n_o, // irq, low
  output logic      [uart_irq_pkg::VEC_W-1:0]                vector_o,            // vector
  output logic                                               vector_oe_o,         // vector en
  input  wire logic [uart_irq_pkg::NUM_CH-1:0][uart_irq_pkg::CNT_W-1:0] rx_count_i, // rx fill
  input  wire logic [uart_irq_pkg::NUM_CH-1:0]               rx_err_i,            // rx error
  input  wire logic [uart_irq_pkg::NUM_CH-1:0][uart_irq_pkg::CNT_W-1:0] tx_empty_i, // tx free
  input  wire logic [uart_irq_pkg::NUM_CH-1:0][uart_irq_pkg::NEVT-1:0]  evt_i,   // events
  input  wire logic [uart_irq_pkg::NUM_CH-1:0]               wdog_i,              // watchdog
  input  wire logic [uart_irq_pkg::NUM_CH-1:0][7:0]          rx_data_i,           // rx heads
  output logic      [uart_irq_pkg::NUM_CH-1:0]               rx_pop_o,            // rx pop
  output logic      [uart_irq_pkg::NUM_CH-1:0]               tx_push_o,           // tx push
  output logic      [7:0]                                    tx_data_o            // tx char
);
  import uart_irq_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [ICR_W-1:0]              interrupt_control_reg;
    logic [NUM_CH*NSRC-1:0]        interrupt_mask_reg;
    logic [VEC_W-1:0]              ivr;
    logic [NUM_CH-1:0][BCR_W-1:0]  bcr;
    logic [BID_W-1:0]              current_interrupt_reg;
    logic                          ack_prev;
    logic [NUM_CH*NEVT-1:0]        evclr;
    logic [DATA_W-1:0]             rdata;
    logic                          irq_n;
    logic [VEC_W-1:0]              vec;
    logic                          vec_oe;
    logic [NUM_CH-1:0]             pop;
    logic [NUM_CH-1:0]             push;
    logic [7:0]                    txd;
  } arb_state_t;

  arb_state_t                          st_q;
  arb_state_t                          st_d;
  logic [NUM_CH-1:0][BID_W-1:0]        ch_bid;
  logic [NUM_CH-1:0]                   ch_valid;
  logic [NUM_CH-1:0][NEVT-1:0]         ch_pend;
  logic [BID_W-1:0]                    win;
  logic                                win_valid;
  logic                                ack_fall;
  logic                                upd_cmd;
  logic                                capture;
  logic [CH_W-1:0]                     ctx_chan;

  function automatic logic [VEC_W-1:0] vec_mod(input logic [VEC_W-1:0] base,
                                               input logic [BID_W-1:0] ctx,
                                               input logic [1:0]       mode);
    logic [VEC_W-1:0] v;
    v = base;
    if (mode[0])
      v[TYPE_LSB +: 4] = ctx[6:3];
    if (mode[1])
      v[CHAN_LSB +: 3] = ctx[2:0];
    return v;
  endfunction : vec_mod

  // ****************************************************************
  // per channel bid builders and the scanner
  // ****************************************************************
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    chan_bid_gen #(
      .CHAN        (3'(c))
    ) u_gen (
      .core_clk_i  (core_clk_i),
      .nrst_i      (nrst_i),
      .rx_count_i  (rx_count_i[c]),
      .rx_err_i    (rx_err_i[c]),
      .tx_empty_i  (tx_empty_i[c]),
      .evt_i       (evt_i[c]),
      .evt_clr_i   (st_q.evclr[c*NEVT +: NEVT]),
      .mask_i      (st_q.interrupt_mask_reg[c*NSRC +: NSRC]),
      .bcr_i       (st_q.bcr[c]),
      .thr_i       (st_q.interrupt_control_reg[ICR_THR_LSB +: THR_W]),
      .wdog_i      (|wdog_i),
      .bid_o       (ch_bid[c]),
      .bid_valid_o (ch_valid[c]),
      .pend_o      (ch_pend[c])
    );
  end

  bid_scanner u_scan (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .bids_i      (ch_bid),
    .valid_i     (ch_valid),
    .win_o       (win),
    .win_valid_o (win_valid)
  );

  // ****************************************************************
  // capture and register access
  // ****************************************************************
  assign ack_fall = st_q.ack_prev && !interrupt_ack_n_i;
  assign upd_cmd  = wr_i && (addr_i == ADDR_CIR);
  assign capture  = ack_fall || upd_cmd;
  assign ctx_chan = st_q.current_interrupt_reg[CH_W-1:0];

  always_comb
  begin
    st_d          = st_q;
    st_d.ack_prev = interrupt_ack_n_i;
    st_d.irq_n    = !win_valid;
    st_d.rdata    = '0;
    st_d.pop      = '0;
    st_d.push     = '0;
    st_d.evclr    = '0;
    if (capture)
      st_d.current_interrupt_reg = win_valid ? win : CIR_RST;
    st_d.vec_oe = !interrupt_ack_n_i;
    st_d.vec    = interrupt_ack_n_i ? '0
                : vec_mod(st_q.ivr, st_d.current_interrupt_reg, st_q.interrupt_control_reg[ICR_VMOD_LSB +: 2]);
    if (wr_i)
    begin
      case (addr_i)
        ADDR_ICR: st_d.interrupt_control_reg = wdata_i[ICR_W-1:0];
        ADDR_IMR: st_d.interrupt_mask_reg = wdata_i[NUM_CH*NSRC-1:0];
        ADDR_IVR: st_d.ivr = wdata_i[VEC_W-1:0];
        ADDR_GTX:
        begin
          st_d.push[ctx_chan] = 1'b1;
          st_d.txd            = wdata_i[7:0];
        end
        ADDR_EVT: st_d.evclr = wdata_i[NUM_CH*NEVT-1:0];
        default:
        begin
          if (addr_i[3:2] == ADDR_BCR_HI)
            st_d.bcr[addr_i[CH_W-1:0]] = wdata_i[BCR_W-1:0];
        end
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        ADDR_ICR: st_d.rdata = DATA_W'(st_q.interrupt_control_reg);
        ADDR_IMR: st_d.rdata = DATA_W'(st_q.interrupt_mask_reg);
        ADDR_IVR: st_d.rdata = DATA_W'(st_q.ivr);
        ADDR_CIR: st_d.rdata = DATA_W'(st_q.current_interrupt_reg);
        ADDR_GRX:
        begin
          st_d.rdata         = DATA_W'(rx_data_i[ctx_chan]);
          st_d.pop[ctx_chan] = 1'b1;
        end
        ADDR_EVT: st_d.rdata = DATA_W'(ch_pend);
        default:
        begin
          if (addr_i[3:2] == ADDR_BCR_HI)
            st_d.rdata = DATA_W'(st_q.bcr[addr_i[CH_W-1:0]]);
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      st_q          <= '0;
      st_q.interrupt_control_reg      <= ICR_RST;
      st_q.interrupt_mask_reg      <= IMR_RST;
      st_q.ivr      <= IVR_RST;
      st_q.bcr      <= {NUM_CH{BCR_RST}};
      st_q.current_interrupt_reg      <= CIR_RST;
      st_q.ack_prev <= 1'b1;
      st_q.irq_n    <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rdata_o               = st_q.rdata;
  assign interrupt_request_n_o = st_q.irq_n;
  assign vector_o              = st_q.vec;
  assign vector_oe_o           = st_q.vec_oe;
  assign rx_pop_o              = st_q.pop;
  assign tx_push_o             = st_q.push;
  assign tx_data_o             = st_q.txd;

  // ****************************************************************
  // checks
  // ****************************************************************
  cir_zero_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (capture && !win_valid) |=> (st_q.current_interrupt_reg == CIR_RST))
    else $error("empty capture did not load zero");

  cir_capture_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (capture && win_valid) |=> (st_q.current_interrupt_reg == $past(win)))
    else $error("capture missed the winning bid");

  cir_hold_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    !capture |=> $stable(st_q.current_interrupt_reg))
    else $error("context changed without capture");

  upd_read_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (upd_cmd && win_valid) ##1 (rd_i && addr_i == ADDR_CIR && !capture)
      |=> (rdata_o[BID_W-1:0] == $past(win, 2)))
    else $error("read after update not the captured bid");

  irq_follow_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!win_valid ##1 !win_valid) |=> interrupt_request_n_o)
    else $error("request held with no active bid");

  vec_drive_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (!interrupt_ack_n_i && st_q.interrupt_control_reg[ICR_VMOD_LSB +: 2] == 2'h0)
      |=> (vector_oe_o && vector_o == st_q.ivr))
    else $error("unmodified vector not driven in ack cycle");

  win_route_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ADDR_GRX) |=> (rx_pop_o == (NUM_CH'(1) << $past(ctx_chan))))
    else $error("global rx window routed to wrong channel");

endmodule : uart_interrupt_arbiter
`default_nettype wire

// ---- inc/uart_irq_pkg.sv ----
// constants shared by the uart interrupt arbiter blocks
package uart_irq_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_CH = 4;
  localparam int CH_W   = 2;
  localparam int BID_W  = 10;
  localparam int THR_W  = 7;
  localparam int CNT_W  = 5;
  localparam int DATA_W = 24;
  localparam int ADDR_W = 4;
  localparam int VEC_W  = 8;
  localparam int NSRC   = 6;
  localparam int NEVT   = 4;
  localparam int BCR_W  = 7;
  localparam int ICR_W  = 9;

  // ****************************************************************
  // arbitration timing: one result every 22 clocks
  // ****************************************************************
  localparam int         ARB_PERIOD = 22;
  localparam logic [4:0] ARB_LAST   = 5'(ARB_PERIOD - 1);

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [3:0] ADDR_ICR      = 4'h0;
  localparam logic [3:0] ADDR_IMR      = 4'h1;
  localparam logic [3:0] ADDR_IVR      = 4'h2;
  localparam logic [3:0] ADDR_CIR      = 4'h3;
  localparam logic [3:0] ADDR_GRX      = 4'h4;
  localparam logic [3:0] ADDR_GTX      = 4'h5;
  localparam logic [3:0] ADDR_EVT      = 4'h6;
  localparam logic [1:0] ADDR_BCR_HI   = 2'h2;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ICR_THR_LSB  = 0;
  localparam int ICR_VMOD_LSB = 7;
  localparam int BCR_PROG_LSB = 0;
  localparam int BCR_RXL_LSB  = 3;
  localparam int BCR_TXL_LSB  = 5;

  // source slots inside one channel's six mask bits
  localparam int SRC_RX  = 0;
  localparam int SRC_TX  = 1;
  localparam int SRC_EVT = 2;

  // low three type bits of the event sources: break, cos, xon/xoff, address
  localparam logic [NEVT-1:0][2:0] EVT_CODE = {3'h3, 3'h7, 3'h6, 3'h2};

  // start levels of receive and transmit bidding
  localparam logic [CNT_W-1:0] LVL_ONE  = 5'h01;
  localparam logic [CNT_W-1:0] LVL_HALF = 5'h08;
  localparam logic [CNT_W-1:0] LVL_3Q   = 5'h0C;
  localparam logic [CNT_W-1:0] LVL_FULL = 5'h10;

  // vector modification modes
  localparam logic [1:0] VMOD_TYPE = 2'h1;
  localparam logic [1:0] VMOD_CHAN = 2'h2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [ICR_W-1:0]       ICR_RST = 9'h000;
  localparam logic [NUM_CH*NSRC-1:0] IMR_RST = 24'h000000;
  localparam logic [VEC_W-1:0]       IVR_RST = 8'h00;
  localparam logic [BCR_W-1:0]       BCR_RST = 7'h00;
  localparam logic [BID_W-1:0]       CIR_RST = 10'h000;

endpackage : uart_irq_pkg

// ---- logic/chan_bid_gen.sv ----
// bid builder for one uart channel: six sources reduced to one bid
`timescale 1ns/1ps
`default_nettype none
module chan_bid_gen #(
  parameter logic [2:0] CHAN = 3'h0
) (
  input  wire logic                           core_clk_i,  // system clock
  input  wire logic                           nrst_i,      // sync reset, low
  input  wire logic [uart_irq_pkg::CNT_W-1:0] rx_count_i,  // filled rx slots
  input  wire logic                           rx_err_i,    // rx head has error
  input  wire logic [uart_irq_pkg::CNT_W-1:0] tx_empty_i,  // empty tx slots
  input  wire logic [uart_irq_pkg::NEVT-1:0]  evt_i,       // event pulses
  input  wire logic [uart_irq_pkg::NEVT-1:0]  evt_clr_i,   // pending clears
  input  wire logic [uart_irq_pkg::NSRC-1:0]  mask_i,      // source enables
  input  wire logic [uart_irq_pkg::BCR_W-1:0] bcr_i,       // bid control
  input  wire logic [uart_irq_pkg::THR_W-1:0] thr_i,       // threshold
  input  wire logic                           wdog_i,      // any watchdog
  output logic      [uart_irq_pkg::BID_W-1:0] bid_o,       // best bid
  output logic                                bid_valid_o, // bid is active
  output logic      [uart_irq_pkg::NEVT-1:0]  pend_o       // pending events
);
  import uart_irq_pkg::*;

  typedef struct packed {
    logic [NEVT-1:0] pend;
  } gen_state_t;

  gen_state_t                   st_q;
  gen_state_t                   st_d;
  logic [NSRC-1:0][BID_W-1:0]   cand;
  logic [NSRC-1:0]              act;
  logic [NSRC-1:0]              ok;
  logic [THR_W-1:0]             thr_eff;
  logic [3:0]                   rx_cm1;
  logic [3:0]                   tx_cm1;

  function automatic logic start_ok(input logic [CNT_W-1:0] cnt, input logic [1:0] lvl);
    logic r;
    case (lvl)
      2'h0:    r = (cnt >= LVL_ONE);
      2'h1:    r = (cnt >= LVL_HALF);
      2'h2:    r = (cnt >= LVL_3Q);
      default: r = (cnt >= LVL_FULL);
    endcase
    return r;
  endfunction : start_ok

  // ****************************************************************
  // source bids
  // ****************************************************************
  assign rx_cm1 = 4'(rx_count_i - LVL_ONE);
  assign tx_cm1 = 4'(tx_empty_i - LVL_ONE);
  assign thr_eff = wdog_i ? '0 : thr_i;  // watchdog forces threshold to zero

  assign cand[SRC_RX] = {rx_cm1, rx_err_i, 1'b0, 1'b1, CHAN};
  assign cand[SRC_TX] = {1'b0, tx_cm1, 2'b00, CHAN};
  assign act[SRC_RX]  = start_ok(rx_count_i, bcr_i[BCR_RXL_LSB +: 2]);
  assign act[SRC_TX]  = start_ok(tx_empty_i, bcr_i[BCR_TXL_LSB +: 2]) && !wdog_i;

  for (genvar k = 0; k < NEVT; k++)
  begin : g_evt
    assign cand[SRC_EVT+k] = {bcr_i[BCR_PROG_LSB +: 3], 1'b0, EVT_CODE[k], CHAN};
    assign act[SRC_EVT+k]  = st_q.pend[k] && !wdog_i;
  end

  for (genvar s = 0; s < NSRC; s++)
  begin : g_ok
    assign ok[s] = act[s] && mask_i[s] && (cand[s][BID_W-1:3] > thr_eff);
  end

  // ****************************************************************
  // best of the active sources
  // ****************************************************************
  always_comb
  begin
    bid_o       = '0;
    bid_valid_o = 1'b0;
    for (int s = 0; s < NSRC; s++)
    begin
      if (ok[s] && (!bid_valid_o || cand[s] > bid_o))
      begin
        bid_o       = cand[s];
        bid_valid_o = 1'b1;
      end
    end
  end

  always_comb
  begin
    st_d      = st_q;
    st_d.pend = (st_q.pend & ~evt_clr_i) | evt_i;  // set wins over clear
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign pend_o = st_q.pend;

  // ****************************************************************
  // checks
  // ****************************************************************
  mask_gate_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (bid_valid_o && bid_o[4:3] == 2'b01) |-> mask_i[SRC_RX])
    else $error("rx bid valid while rx source masked");

  thr_strict_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (bid_valid_o && !wdog_i) |-> (bid_o[BID_W-1:3] > thr_i))
    else $error("bid not above threshold yet valid");

  rx_full_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (bid_valid_o && bid_o[4:3] == 2'b01 && bcr_i[BCR_RXL_LSB +: 2] == 2'h3)
      |-> (rx_count_i == LVL_FULL))
    else $error("rx bid before full level");

  evt_active_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (bid_valid_o && bid_o[4]) |-> (|st_q.pend))
    else $error("event bid with no pending event");

endmodule : chan_bid_gen
`default_nettype wire

// ---- logic/bid_scanner.sv ----
// serial scan of channel bids, one winner every arbitration period
`timescale 1ns/1ps
`default_nettype none
module bid_scanner (
  input  wire logic                                                core_clk_i,  // clock
  input  wire logic                                                nrst_i,      // reset
  input  wire logic [uart_irq_pkg::NUM_CH-1:0][uart_irq_pkg::BID_W-1:0] bids_i, // bids
  input  wire logic [uart_irq_pkg::NUM_CH-1:0]                     valid_i,     // actives
  output logic      [uart_irq_pkg::BID_W-1:0]                      win_o,       // winner
  output logic                                                     win_valid_o  // any win
);
  import uart_irq_pkg::*;

  typedef struct packed {
    logic [4:0]                   cnt;
    logic [NUM_CH-1:0][BID_W-1:0] snap;
    logic [NUM_CH-1:0]            snapv;
    logic [BID_W-1:0]             best;
    logic                         bestv;
    logic [BID_W-1:0]             win;
    logic                         winv;
  } scan_state_t;

  scan_state_t     st_q;
  scan_state_t     st_d;
  logic [CH_W-1:0] idx;

  assign idx = CH_W'(st_q.cnt - 5'h01);

  // ****************************************************************
  // snapshot at step zero, compare one channel per step
  // ****************************************************************
  always_comb
  begin
    st_d     = st_q;
    st_d.cnt = (st_q.cnt == ARB_LAST) ? 5'h00 : 5'(st_q.cnt + 5'h01);
    if (st_q.cnt == 5'h00)
    begin
      st_d.snap  = bids_i;  // later changes wait for the next period
      st_d.snapv = valid_i;
      st_d.best  = '0;
      st_d.bestv = 1'b0;
    end
    else if (st_q.cnt <= 5'(NUM_CH))
    begin
      if (st_q.snapv[idx] && (!st_q.bestv || st_q.snap[idx] > st_q.best))
      begin
        st_d.best  = st_q.snap[idx];
        st_d.bestv = 1'b1;
      end
    end
    if (st_q.cnt == ARB_LAST)
    begin
      st_d.win  = st_q.best;
      st_d.winv = st_q.bestv;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign win_o       = st_q.win;
  assign win_valid_o = st_q.winv;

  // ****************************************************************
  // checks
  // ****************************************************************
  scan_period_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ($changed(st_q.win) || $changed(st_q.winv)) |-> ($past(st_q.cnt) == ARB_LAST))
    else $error("winner changed outside period end");

  scan_wrap_a: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (st_q.cnt == 5'h00) |-> ##21 (st_q.cnt == ARB_LAST) ##1 (st_q.cnt == 5'h00))
    else $error("arbitration period not 22 clocks");

endmodule : bid_scanner
`default_nettype wire

// ---- tb/ack_host.sv ----
// host side model answering requests with an acknowledge cycle
`timescale 1ns/1ps
`default_nettype none
module ack_host (
  input  wire logic core_clk_i, // clock
  input  wire logic go_i,       // start one cycle
  input  wire logic irq_n_i,    // request, low
  output logic      ack_n_o     // acknowledge, low
);
  logic [2:0] hold_q = 3'h0;
  // answers only a standing request, ack held four clocks
  always @(posedge core_clk_i)
    hold_q <= (go_i && !irq_n_i) ? 3'h4 : hold_q - 3'(hold_q != 3'h0);
  assign ack_n_o = (hold_q == 3'h0);
endmodule : ack_host
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench of the uart interrupt arbiter
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("BAD %0t %h vs %h", $time, a, b); end end
module tb;
  import uart_irq_pkg::*;
  logic                         clk = 0, nrst = 0, wr = 0, rd = 0, go = 0, ack_n, irq_n, voe;
  logic [ADDR_W-1:0]            addr = '0;
  logic [DATA_W-1:0]            wd = '0, rdv, rd_o;
  logic [NUM_CH-1:0][CNT_W-1:0] rxc = '0;
  logic [VEC_W-1:0]             vec, ivr;
  logic [BID_W-1:0]             exp_c;
  logic [NUM_CH-1:0][CNT_W-1:0] txe = '0;
  logic [NUM_CH-1:0][NEVT-1:0]  ev = '0;
  logic [NUM_CH-1:0]            pv, pop, push;
  logic [31:0]                  rxd = '0;
  logic [23:0]                  xm = '0;
  logic [7:0]                   txd;
  logic [31:0]                  seed = 32'h0000B825;
  int                           err_total = 0, n_checks = 0, i, k;
  always #20 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // highest receiver bid above threshold, channel bits break ties
  function automatic logic [BID_W-1:0] best(input logic [3:0] m, input logic [6:0] t);
    logic [BID_W-1:0] b, w;
    w = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      b = {4'(rxc[c] - 5'h01), 3'h1, 3'(c)};
      if (m[c] && rxc[c] != 5'h00 && b[9:3] > t && b > w) w = b;
    end
    return w;
  endfunction : best
  task wreg(input logic [3:0] a, input logic [23:0] d);
    @(posedge clk); addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [3:0] a);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 rdv = rd_o;
    pv = pop;
  endtask : rreg
  task setup(input logic [3:0] m, input logic [6:0] t);
    wreg(ADDR_IMR, 24'({m[3], 5'h00, m[2], 5'h00, m[1], 5'h00, m[0]}) | xm);
    wreg(ADDR_ICR, {17'h00000, t});
    repeat (70) @(posedge clk);
    exp_c = best(m, t);
    wreg(ADDR_CIR, 24'h000000);
    rreg(ADDR_CIR);
  endtask : setup
  task close_out();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  ack_host ack_host_inst (.core_clk_i(clk), .go_i(go), .irq_n_i(irq_n), .ack_n_o(ack_n));
  uart_interrupt_arbiter uart_interrupt_arbiter_inst (
    .core_clk_i(clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd),
    .rdata_o(rd_o), .interrupt_ack_n_i(ack_n), .interrupt_request_n_o(irq_n),
    .vector_o(vec), .vector_oe_o(voe), .rx_count_i(rxc), .rx_err_i('0), .tx_empty_i(txe),
    .evt_i(ev), .wdog_i('0), .rx_data_i(rxd), .rx_pop_o(pop), .tx_push_o(push),
    .tx_data_o(txd));
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rreg(ADDR_CIR);
    `CHK(rdv, 24'h000000)
    rxc <= {5'h00, 5'h00, 5'h05, 5'h00};
    setup(4'hF, 7'h21);
    `CHK(rdv, 24'h000000)
    `CHK(irq_n, 1'b1)
    setup(4'hF, 7'h20);
    `CHK(rdv, 24'h000109)
    for (k = 0; k < 12; k++)
    begin
      for (i = 0; i < NUM_CH; i++) rxc[i] <= 5'(rnd() % 17);
      setup(4'(rnd()), (k % 2) ? 7'(rnd() % 80) : 7'h00);
      `CHK(rdv, 24'(exp_c))
      `CHK(irq_n, exp_c == 10'h000)
    end
    ivr = 8'(rnd());
    wreg(ADDR_IVR, {16'h0000, ivr});
    rxc <= {5'(rnd() % 17), 5'h10, 5'(rnd() % 17), 5'h03};
    setup(4'hF, 7'h00);
    `CHK(rdv, 24'(exp_c))
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    for (i = 0; i < 20 && voe !== 1'b1; i++) @(posedge clk) #1;
    `CHK(voe, 1'b1)
    `CHK(vec, ivr)
    repeat (8) @(posedge clk);
    rreg(ADDR_CIR);
    `CHK(rdv, 24'(exp_c))
    rxc <= {5'h00, 5'h00, 5'h00, 5'h10};
    repeat (70) @(posedge clk);
    rreg(ADDR_CIR);
    `CHK(rdv, 24'(exp_c))
    rxd <= rnd();
    rreg(ADDR_GRX);
    `CHK(rdv, 24'(rxd[8*exp_c[1:0] +: 8]))
    `CHK(pv, 4'h1 << exp_c[1:0])
    wreg(ADDR_GTX, 24'h0000A5);
    #1 `CHK(push, 4'h1 << exp_c[1:0])
    `CHK(txd, 8'hA5)
    // transmitters only: emptier fifo wins over higher channel
    txe <= {5'h09, 5'h00, 5'h0F, 5'h00};
    xm = 24'h080080;
    setup(4'h0, 7'h00);
    `CHK(rdv, 24'h0001C1)
    wreg({ADDR_BCR_HI, 2'h1}, 24'h000060);
    setup(4'h0, 7'h00);
    `CHK(rdv, 24'h000103)
    // break events: programmed high bits outrank the higher channel
    xm = 24'h104000;
    wreg({ADDR_BCR_HI, 2'h2}, 24'h000005);
    ev <= 16'h1100;
    @(posedge clk) ev <= '0;
    setup(4'h0, 7'h00);
    `CHK(rdv, 24'h000292)
    rreg(ADDR_EVT);
    `CHK(rdv, 24'h001100)
    close_out();
  end
endmodule : tb
`default_nettype wire
